//--- rtl/ucx_pkg.sv
// Constants shared by the serial controller design.
package ucx_pkg;
    localparam int UCX_DATA_W      = 8;
    localparam int UCX_FIFO_DEPTH  = 32;
    localparam int UCX_BIT_TICKS   = 16;
    localparam int UCX_TBE_TICK    = 4;
    localparam int UCX_SDO_TICK    = 5;
    localparam int UCX_CHAIN_TICK  = 15;
    localparam int UCX_FLAG_TICK   = 11;
    localparam int UCX_SAMPLE_TICK = 8;
    localparam int UCX_BSR_CO_SEL  = 7;
    localparam int UCX_BSR_EXT     = 6;
    localparam int UCX_ST_DR       = 7;
    localparam int UCX_ST_TBE      = 6;
    localparam int UCX_ST_TC       = 5;
    localparam int UCX_ST_MS       = 4;
    localparam int UCX_ST_BRK      = 3;
    localparam int UCX_ST_FE       = 2;
    localparam int UCX_ST_PE       = 1;
    localparam int UCX_ST_OE       = 0;
    localparam logic [7:0] UCX_BSR_RST = 8'h00;
    typedef enum logic [1:0] {TX_IDLE, TX_ARM, TX_RUN} ucx_tx_st_t;
    typedef enum logic [1:0] {RX_IDLE, RX_RUN, RX_WAIT} ucx_rx_st_t;
endpackage : ucx_pkg

//--- rtl/ucx_uart.sv
// Serial controller: baud generator, transmitter, receiver, status and modem lines.
`timescale 1ns/1ns

module ucx_fifo #(
    parameter int W = 8,
    parameter int D = 32
) (
    input  wire logic         i_mclk,      // System clock.
    input  wire logic         i_rst_n,     // Synchronous reset, active low.
    input  wire logic         i_in_valid,  // Write request.
    output logic              o_in_ready,  // Room for a word.
    input  wire logic [W-1:0] i_in_data,   // Word written.
    output logic              o_out_valid, // Word available.
    input  wire logic         i_out_ready, // Word taken.
    output logic [W-1:0]      o_out_data   // Oldest word.
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr_ff;
    logic [AW:0]  rd_ptr_ff;
    logic         push;
    logic         pop;

    assign o_in_ready  = (wr_ptr_ff - rd_ptr_ff) != (AW+1)'(D);
    assign o_out_valid = wr_ptr_ff != rd_ptr_ff;
    assign o_out_data  = mem[rd_ptr_ff[AW-1:0]];
    assign push        = i_in_valid && o_in_ready;
    assign pop         = o_out_valid && i_out_ready;

    always_ff @(posedge i_mclk)
    begin
        if (push)
        begin
            mem[wr_ptr_ff[AW-1:0]] <= i_in_data;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            wr_ptr_ff <= '0;
            rd_ptr_ff <= '0;
        end
        else
        begin
            wr_ptr_ff <= wr_ptr_ff + (AW+1)'(push);
            rd_ptr_ff <= rd_ptr_ff + (AW+1)'(pop);
        end
    end
endmodule : ucx_fifo

module ucx_uart
    import ucx_pkg::*;
(
    input  wire logic       i_mclk,         // System clock, 25 MHz.
    input  wire logic       i_rst_n,        // Synchronous reset, active low.
    input  wire logic       i_wr_baud,      // Baud select write pulse.
    input  wire logic [7:0] i_baud_data,    // Baud select value.
    input  wire logic       i_wr_modem,     // Modem control write pulse.
    input  wire logic [1:0] i_modem_data,   // Bit 0 RTS, bit 1 DTR, 1 means active.
    input  wire logic       i_parity_en,    // Parity bit present.
    input  wire logic       i_parity_odd,   // Odd parity when set.
    input  wire logic       i_interrupt_enable_bit,        // General interrupt enable.
    input  wire logic       i_modem_interrupt_enable_bit,         // Modem interrupt enable.
    input  wire logic       i_tx_valid,     // Character offered for sending.
    output logic            o_tx_ready,     // Transmit queue has room.
    input  wire logic [7:0] i_tx_data,      // Character to send.
    input  wire logic       i_rd_rx,        // Receive buffer read pulse.
    input  wire logic       i_rd_status,    // Status read pulse.
    input  wire logic       i_serial_in,    // Serial input line.
    input  wire logic       i_cts_n,        // Clear to send, active low.
    input  wire logic       i_dsr_n,        // Data set ready, active low.
    output logic            o_serial_out,   // Serial output line.
    output logic            o_rts_n,        // Request to send, active low.
    output logic            o_dtr_n,        // Data terminal ready, active low.
    output logic            o_clock_output, // Clock output pin.
    output logic [7:0]      o_rx_buffer,    // Last received character.
    output logic [7:0]      o_status,       // Status register.
    output logic            o_tx_buffer_empty, // Holding buffer empty.
    output logic            o_rx_data_ready,   // Received character waiting.
    output logic            o_interrupt_request // Interrupt request.
);
    logic [7:0] bsr_ff;
    logic [6:0] div_cnt_ff;
    logic [6:0] div_n;
    logic       tick;
    logic       bclk_ff;
    logic       fifo_valid;
    logic [7:0] fifo_data;
    logic       load_hold;
    logic [7:0] hold_ff;
    logic       hold_full_ff;
    ucx_tx_st_t tx_st_ff;
    logic [2:0] arm_cnt_ff;
    logic [4:0] tx_sub_ff;
    logic [3:0] tx_bit_ff;
    logic [10:0] tx_shift_ff;
    logic       chain_ff;
    logic       serial_out_ff;
    logic [3:0] last_idx;
    logic       tx_last_tick;
    logic       tx_move;
    logic [10:0] frame;
    ucx_rx_st_t rx_st_ff;
    logic [4:0] rx_sub_ff;
    logic [3:0] rx_bit_ff;
    logic [9:0] rx_shift_ff;
    logic       rx_done;
    logic [7:0] rx_word;
    logic       dr_ff;
    logic       tc_ff;
    logic       ms_ff;
    logic       oe_ff;
    logic       fe_ff;
    logic       pe_ff;
    logic       brk_ff;
    logic       cts_prev_ff;
    logic       dsr_prev_ff;
    logic       rts_n_ff;
    logic       dtr_n_ff;
    logic       modem_chg;

    assign div_n = bsr_ff[UCX_BSR_EXT] ? 7'h01 : {1'b0, bsr_ff[5:0]} + 7'h01;
    // A shorter divisor written mid-count must not let the counter run past it.
    assign tick  = div_cnt_ff >= div_n - 7'h01;

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            bsr_ff     <= UCX_BSR_RST;
            div_cnt_ff <= '0;
            bclk_ff    <= 1'b0;
        end
        else
        begin
            if (i_wr_baud)
            begin
                bsr_ff <= i_baud_data;
            end
            div_cnt_ff <= tick ? 7'h00 : div_cnt_ff + 7'h01;
            bclk_ff    <= tick || (div_cnt_ff + 7'h01 < (div_n >> 1));
        end
    end

    // Divide-by-one mirrors the input clock itself.
    assign o_clock_output = (!bsr_ff[UCX_BSR_CO_SEL] || bsr_ff[UCX_BSR_EXT]) ?
                            i_mclk : bclk_ff;

    ucx_fifo #(.W(UCX_DATA_W), .D(UCX_FIFO_DEPTH)) u_txq (
        .i_mclk      (i_mclk),
        .i_rst_n     (i_rst_n),
        .i_in_valid  (i_tx_valid),
        .o_in_ready  (o_tx_ready),
        .i_in_data   (i_tx_data),
        .o_out_valid (fifo_valid),
        .i_out_ready (!hold_full_ff),
        .o_out_data  (fifo_data)
    );

    assign load_hold    = fifo_valid && !hold_full_ff;
    assign last_idx     = i_parity_en ? 4'd10 : 4'd9;
    assign tx_last_tick = tx_st_ff == TX_RUN && tick && tx_bit_ff == last_idx;
    assign tx_move      = (tx_st_ff == TX_ARM && tick && arm_cnt_ff == 3'(UCX_TBE_TICK - 1))
                       || (tx_last_tick && tx_sub_ff == 5'(UCX_CHAIN_TICK - 1)
                           && hold_full_ff && !i_cts_n);
    assign frame = {1'b1, i_parity_en ? (^hold_ff ^ i_parity_odd) : 1'b1, hold_ff, 1'b0};

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            hold_full_ff <= 1'b0;
            hold_ff      <= '0;
        end
        else if (load_hold)
        begin
            hold_full_ff <= 1'b1;
            hold_ff      <= fifo_data;
        end
        else if (tx_move)
        begin
            hold_full_ff <= 1'b0;
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            tx_st_ff      <= TX_IDLE;
            arm_cnt_ff    <= '0;
            tx_sub_ff     <= '0;
            tx_bit_ff     <= '0;
            tx_shift_ff   <= '1;
            chain_ff      <= 1'b0;
            serial_out_ff <= 1'b1;
        end
        else
        begin
            if (tx_move)
            begin
                tx_shift_ff <= frame;
            end
            unique case (tx_st_ff)
                TX_IDLE:
                begin
                    arm_cnt_ff <= '0;
                    if (hold_full_ff && !i_cts_n)
                    begin
                        tx_st_ff <= TX_ARM;
                    end
                end
                TX_ARM:
                begin
                    if (tick)
                    begin
                        arm_cnt_ff <= arm_cnt_ff + 3'd1;
                        if (arm_cnt_ff == 3'(UCX_SDO_TICK - 1))
                        begin
                            tx_st_ff      <= TX_RUN;
                            tx_sub_ff     <= '0;
                            tx_bit_ff     <= '0;
                            serial_out_ff <= tx_shift_ff[0];
                        end
                    end
                end
                TX_RUN:
                begin
                    if (tx_move)
                    begin
                        chain_ff <= 1'b1;
                    end
                    if (tick)
                    begin
                        tx_sub_ff <= tx_sub_ff + 5'd1;
                        if (tx_sub_ff == 5'(UCX_BIT_TICKS - 1))
                        begin
                            tx_sub_ff <= '0;
                            tx_bit_ff <= tx_bit_ff + 4'd1;
                            if (tx_bit_ff != last_idx)
                            begin
                                tx_shift_ff   <= {1'b1, tx_shift_ff[10:1]};
                                serial_out_ff <= tx_shift_ff[1];
                            end
                            else if (chain_ff)
                            begin
                                chain_ff      <= 1'b0;
                                tx_bit_ff     <= '0;
                                serial_out_ff <= tx_shift_ff[0];
                            end
                            else
                            begin
                                tx_st_ff <= TX_IDLE;
                            end
                        end
                    end
                end
            endcase
        end
    end

    assign o_serial_out      = serial_out_ff;
    assign o_tx_buffer_empty = !hold_full_ff;

    assign rx_done = rx_st_ff == RX_RUN && tick && rx_bit_ff == last_idx
                     && rx_sub_ff == 5'(UCX_FLAG_TICK - 1);
    assign rx_word = i_parity_en ? rx_shift_ff[7:0] : rx_shift_ff[8:1];

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            rx_st_ff    <= RX_IDLE;
            rx_sub_ff   <= '0;
            rx_bit_ff   <= '0;
            rx_shift_ff <= '0;
        end
        else
        begin
            unique case (rx_st_ff)
                RX_IDLE:
                begin
                    rx_sub_ff <= '0;
                    rx_bit_ff <= '0;
                    if (!i_serial_in)
                    begin
                        rx_st_ff <= RX_RUN;
                    end
                end
                RX_RUN:
                begin
                    if (tick)
                    begin
                        rx_sub_ff <= rx_sub_ff + 5'd1;
                        if (rx_sub_ff == 5'(UCX_SAMPLE_TICK - 1))
                        begin
                            if (rx_bit_ff == 4'd0 && i_serial_in)
                            begin
                                rx_st_ff <= RX_IDLE;
                            end
                            else if (rx_bit_ff != 4'd0)
                            begin
                                rx_shift_ff <= {i_serial_in, rx_shift_ff[9:1]};
                            end
                        end
                        if (rx_done)
                        begin
                            rx_st_ff <= RX_WAIT;
                        end
                        else if (rx_sub_ff == 5'(UCX_BIT_TICKS - 1))
                        begin
                            rx_sub_ff <= '0;
                            rx_bit_ff <= rx_bit_ff + 4'd1;
                        end
                    end
                end
                RX_WAIT:
                begin
                    if (i_serial_in)
                    begin
                        rx_st_ff <= RX_IDLE;
                    end
                end
                default:
                begin
                    rx_st_ff <= RX_IDLE;
                end
            endcase
        end
    end

    // Flags: a setting event wins over a clearing read in the same cycle.
    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            dr_ff       <= 1'b0;
            o_rx_buffer <= '0;
            oe_ff       <= 1'b0;
            fe_ff       <= 1'b0;
            pe_ff       <= 1'b0;
            brk_ff      <= 1'b0;
        end
        else if (rx_done)
        begin
            dr_ff       <= 1'b1;
            o_rx_buffer <= rx_word;
            oe_ff       <= dr_ff && !i_rd_rx;
            fe_ff       <= !rx_shift_ff[9];
            pe_ff       <= i_parity_en && ((^rx_shift_ff[8:0]) != i_parity_odd);
            brk_ff      <= rx_shift_ff == 10'h000;
        end
        else
        begin
            dr_ff <= dr_ff && !i_rd_rx;
            if (i_rd_status)
            begin
                oe_ff  <= 1'b0;
                fe_ff  <= 1'b0;
                pe_ff  <= 1'b0;
                brk_ff <= 1'b0;
            end
        end
    end

    assign modem_chg = (i_cts_n != cts_prev_ff) || (i_dsr_n != dsr_prev_ff);

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            tc_ff       <= 1'b0;
            ms_ff       <= 1'b0;
            cts_prev_ff <= 1'b1;
            dsr_prev_ff <= 1'b1;
        end
        else
        begin
            cts_prev_ff <= i_cts_n;
            dsr_prev_ff <= i_dsr_n;
            if (tx_last_tick && tx_sub_ff == 5'(UCX_FLAG_TICK - 1) && !hold_full_ff)
            begin
                tc_ff <= 1'b1;
            end
            else if (i_rd_status)
            begin
                tc_ff <= 1'b0;
            end
            if (modem_chg)
            begin
                ms_ff <= 1'b1;
            end
            else if (i_rd_status)
            begin
                ms_ff <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_mclk)
    begin
        if (!i_rst_n)
        begin
            rts_n_ff <= 1'b1;
            dtr_n_ff <= 1'b1;
        end
        else if (i_wr_modem)
        begin
            rts_n_ff <= !i_modem_data[0];
            dtr_n_ff <= !i_modem_data[1];
        end
    end

    assign o_rts_n         = rts_n_ff;
    assign o_dtr_n         = dtr_n_ff;
    assign o_rx_data_ready = dr_ff;
    assign o_status = {dr_ff, !hold_full_ff, tc_ff, ms_ff, brk_ff, fe_ff, pe_ff, oe_ff};
    assign o_interrupt_request = (i_interrupt_enable_bit && (tc_ff || dr_ff || oe_ff || fe_ff || pe_ff || brk_ff))
                              || (i_interrupt_enable_bit && i_modem_interrupt_enable_bit && ms_ff);

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rst_n);

    sequence s_arm_last;
        tx_st_ff == TX_ARM && tick && arm_cnt_ff == 3'd4;
    endsequence
    sequence s_stop_chain;
        tx_last_tick && tx_sub_ff == 5'd14 && hold_full_ff && !i_cts_n;
    endsequence

    a_tx_fifth_start: assert property (s_arm_last |=> tx_st_ff == TX_RUN && !o_serial_out)
        else $error("Start bit not driven on fifth tick.");
    a_tx_fourth_empty: assert property (tx_st_ff == TX_ARM && tick && arm_cnt_ff == 3'd3
        && !fifo_valid |=> o_tx_buffer_empty ##0 tx_st_ff == TX_ARM)
        else $error("Buffer empty not raised on fourth tick.");
    a_status_tbe: assert property (o_status[UCX_ST_TBE] == o_tx_buffer_empty)
        else $error("Status D6 differs from buffer empty.");
    a_chain_empty: assert property (s_stop_chain |=> o_tx_buffer_empty && chain_ff)
        else $error("Chained buffer not emptied at fifteenth tick.");
    a_chain_start: assert property (tx_last_tick && tx_sub_ff == 5'd15 && chain_ff
        |=> !o_serial_out && tx_bit_ff == 4'd0)
        else $error("Chained character did not start.");
    a_cts_holds: assert property (tx_st_ff == TX_IDLE && i_cts_n |=> tx_st_ff != TX_ARM)
        else $error("Transmission armed while clear-to-send high.");
    a_dr_rise: assert property (rx_done |=> o_rx_data_ready && o_status[UCX_ST_DR])
        else $error("Data ready not raised at eleventh tick.");
    a_ms_set: assert property ($changed(i_cts_n) |=> o_status[UCX_ST_MS])
        else $error("Modem change flag not set.");
    a_rts_follow: assert property (i_wr_modem |=> o_rts_n == !$past(i_modem_data[0])
        && o_dtr_n == !$past(i_modem_data[1]))
        else $error("Modem outputs did not follow write.");
    a_irq_gate: assert property (!i_interrupt_enable_bit |-> !o_interrupt_request)
        else $error("Interrupt raised while disabled.");
    a_ext_tick: assert property (bsr_ff[UCX_BSR_EXT] |-> tick)
        else $error("Divide-by-one baud tick missing.");
endmodule : ucx_uart

//--- dv/ucx_remote.sv
// Remote serial equipment model: frame sender, frame decoder and modem inputs.
`timescale 1ns/1ns

module ucx_remote
    import ucx_pkg::*;
(
    input  wire logic i_mclk,       // System clock.
    input  wire logic i_line,       // Line from the design.
    input  wire logic i_parity_en,  // Parity bit present.
    input  wire logic i_parity_odd, // Odd parity when set.
    output logic      o_line,       // Line to the design, idle high.
    output logic      o_cts_n,      // Clear to send, active low.
    output logic      o_dsr_n       // Data set ready, active low.
);
    logic [7:0] rx_q[$];
    int         stop_q[$];
    int         run = 0;

    initial
    begin
        o_line  = 1'b1;
        o_cts_n = 1'b1;
        o_dsr_n = 1'b1;
    end

    task automatic bit_out(input logic b);
        o_line = b;
        repeat (UCX_BIT_TICKS) @(posedge i_mclk);
        #2;
    endtask : bit_out

    task automatic send(input logic [7:0] d, input logic bad_par, input logic stop);
        bit_out(1'b0);
        for (int i = 0; i < 8; i++)
            bit_out(d[i]);
        if (i_parity_en)
            bit_out(^d ^ i_parity_odd ^ bad_par);
        bit_out(stop);
        o_line = 1'b1;
    endtask : send

    // Raising clear-to-send before the fifteenth tick of the stop bit keeps the next character back.
    task automatic set_modem(input logic cts_n, input logic dsr_n);
        o_cts_n = cts_n;
        o_dsr_n = dsr_n;
    endtask : set_modem

    // Decodes frames sent without parity; stop_q holds the length of the preceding stop bit.
    initial
    begin : decode
        logic [7:0] d;
        forever
        begin
            @(posedge i_mclk);
            if (i_line === 1'b1)
                run++;
            else
            begin
                stop_q.push_back(run + 9);
                repeat (8) @(posedge i_mclk);
                for (int i = 0; i < 8; i++)
                begin
                    repeat (UCX_BIT_TICKS) @(posedge i_mclk);
                    d[i] = i_line;
                end
                repeat (UCX_BIT_TICKS) @(posedge i_mclk);
                rx_q.push_back(d);
                run = 0;
            end
        end
    end
endmodule : ucx_remote

//--- dv/ucx_uart_tb_top.sv
// Self-checking bench for the serial controller: clock select, modem, receive and transmit.
`timescale 1ns/1ns

module ucx_uart_tb_top;
    import ucx_pkg::*;
    localparam int TD = 2;
    localparam int WB = 0;
    localparam int WM = 1;
    localparam int RR = 2;
    localparam int RS = 3;
    logic       i_mclk = 1'b0, i_rst_n = 1'b0, i_wr_baud = 1'b0, i_wr_modem = 1'b0;
    logic       i_rd_rx = 1'b0, i_rd_status = 1'b0, i_tx_valid = 1'b0;
    logic       i_parity_en = 1'b0, i_parity_odd = 1'b0, i_interrupt_enable_bit = 1'b0, i_modem_interrupt_enable_bit = 1'b0;
    logic [7:0] i_baud_data = 8'h00, i_tx_data = 8'h00;
    logic [1:0] i_modem_data = 2'h0;
    logic       i_serial_in, i_cts_n, i_dsr_n, o_tx_ready, o_serial_out, o_rts_n;
    logic       o_dtr_n, o_clock_output, o_tx_buffer_empty, o_rx_data_ready;
    logic       o_interrupt_request;
    logic [7:0] o_rx_buffer, o_status;
    int         n_errors = 0;
    int         n_compared = 0;
    logic [7:0] rx_d [5] = '{8'h3C, 8'h5A, 8'h81, 8'h00, 8'h22};
    logic [3:0] rx_f [5] = '{4'h0, 4'h2, 4'h4, 4'hE, 4'h1};
    logic [4:0] rx_bp = 5'b01010;
    logic [4:0] rx_st = 5'b10011;
    logic [4:0] rx_rd = 5'b10111;

    always #20 i_mclk = ~i_mclk;

    ucx_uart uut (
        .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_wr_baud(i_wr_baud), .i_baud_data(i_baud_data),
        .i_wr_modem(i_wr_modem), .i_modem_data(i_modem_data), .i_parity_en(i_parity_en),
        .i_parity_odd(i_parity_odd), .i_interrupt_enable_bit(i_interrupt_enable_bit), .i_modem_interrupt_enable_bit(i_modem_interrupt_enable_bit),
        .i_tx_valid(i_tx_valid), .o_tx_ready(o_tx_ready), .i_tx_data(i_tx_data),
        .i_rd_rx(i_rd_rx), .i_rd_status(i_rd_status), .i_serial_in(i_serial_in),
        .i_cts_n(i_cts_n), .i_dsr_n(i_dsr_n), .o_serial_out(o_serial_out),
        .o_rts_n(o_rts_n), .o_dtr_n(o_dtr_n), .o_clock_output(o_clock_output),
        .o_rx_buffer(o_rx_buffer), .o_status(o_status),
        .o_tx_buffer_empty(o_tx_buffer_empty), .o_rx_data_ready(o_rx_data_ready),
        .o_interrupt_request(o_interrupt_request));

    ucx_remote remote (
        .i_mclk(i_mclk), .i_line(o_serial_out), .i_parity_en(i_parity_en),
        .i_parity_odd(i_parity_odd), .o_line(i_serial_in), .o_cts_n(i_cts_n),
        .o_dsr_n(i_dsr_n));

    task automatic tick(input int n);
        repeat (n)
        begin
            @(posedge i_mclk);
            #TD;
        end
    endtask : tick

    task automatic cmp_val(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_val

    task automatic cmp_cnt(input int got, input int exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            n_errors++;
            $display("Error at %0t ns: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : cmp_cnt

    // One-cycle write or read strobe, followed by a quiet cycle.
    task automatic strobe(input int which, input logic [7:0] v);
        i_baud_data  = v;
        i_modem_data = v[1:0];
        case (which)
            WB: i_wr_baud = 1'b1;
            WM: i_wr_modem = 1'b1;
            RR: i_rd_rx = 1'b1;
            default: i_rd_status = 1'b1;
        endcase
        tick(1);
        {i_wr_baud, i_wr_modem, i_rd_rx, i_rd_status} = 4'h0;
        tick(1);
    endtask : strobe

    task automatic clk_check(input logic [7:0] v, input int follow);
        int   nd;
        int   nc;
        logic a;
        logic b;
        logic p;
        strobe(WB, v);
        nd = 0;
        nc = 0;
        p  = o_clock_output;
        repeat (16)
        begin
            a = o_clock_output;
            @(negedge i_mclk);
            #TD;
            b = o_clock_output;
            nd += int'(a !== b);
            nc += int'(a !== p);
            p = a;
            tick(1);
        end
        cmp_cnt(nd, follow * 16, "clock output phases");
        if (follow == 0)
            cmp_cnt(int'(nc > 0), 1, "baud clock output toggles");
    endtask : clk_check

    // Buffer empty must drop, rise again, and the start bit follow one baud tick later.
    task automatic tbe_to_start();
        int k;
        k = 0;
        while (o_tx_buffer_empty !== 1'b0 && k < 400)
        begin
            tick(1);
            k++;
        end
        while (o_tx_buffer_empty !== 1'b1 && k < 800)
        begin
            tick(1);
            k++;
        end
        cmp_val(8'(o_status[UCX_ST_TBE]), 8'h01, "status tbe");
        k = 0;
        while (o_serial_out !== 1'b0 && k < 20)
        begin
            tick(1);
            k++;
        end
        cmp_cnt(k, 1, "tbe to start bit");
    endtask : tbe_to_start

    task automatic frames(input int cnt, input logic irq_exp);
        int k;
        k = 0;
        while (remote.rx_q.size() < cnt && k < 8000)
        begin
            tick(1);
            k++;
        end
        cmp_val(8'(o_status[UCX_ST_TC]), 8'h00, "tc before tick 11");
        tick(6);
        cmp_val(8'(o_status[UCX_ST_TC]), 8'h01, "tc");
        cmp_val(8'(o_interrupt_request), 8'(irq_exp), "tc irq");
        strobe(RS, 8'h00);
        cmp_val(8'(o_interrupt_request), 8'h00, "irq after status read");
    endtask : frames

    task automatic give_verdict();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : give_verdict

    initial
    begin
        tick(20000);
        n_errors++;
        give_verdict();
    end

    initial
    begin
        int n;
        tick(2);
        i_rst_n = 1'b1;
        cmp_val(o_status, 8'h40, "reset status");
        cmp_val({4'h0, o_serial_out, o_rts_n, o_dtr_n, o_interrupt_request}, 8'h0E, "reset pins");
        clk_check(8'h00, 1);
        clk_check(8'h83, 0);
        clk_check(8'h40, 1);
        $display("test clock select done");
        for (int v = 0; v < 4; v++)
        begin
            strobe(WM, 8'(v));
            cmp_val({6'h00, o_dtr_n, o_rts_n}, 8'(~v & 3), "modem outputs");
        end
        i_interrupt_enable_bit = 1'b1;
        remote.set_modem(1'b0, 1'b1);
        tick(2);
        cmp_val({o_status[UCX_ST_MS], o_interrupt_request}, 2'b10, "ms no modem_interrupt_enable_bit");
        strobe(RS, 8'h00);
        i_modem_interrupt_enable_bit = 1'b1;
        remote.set_modem(1'b0, 1'b0);
        tick(2);
        cmp_val({o_status[UCX_ST_MS], o_interrupt_request}, 2'b11, "ms with modem_interrupt_enable_bit");
        strobe(RS, 8'h00);
        cmp_val({o_status[UCX_ST_MS], o_interrupt_request}, 2'b00, "ms read");
        i_modem_interrupt_enable_bit = 1'b0;
        $display("test modem done");
        i_parity_en  = 1'b1;
        i_parity_odd = 1'b1;
        for (int i = 0; i < 5; i++)
        begin
            fork
                remote.send(rx_d[i], rx_bp[i], rx_st[i]);
                begin
                    tick(166);
                    cmp_val(8'(o_rx_data_ready), 8'(i == 4), "dr before tick 11");
                end
            join
            cmp_val({o_rx_data_ready, o_status[7]}, 2'b11, "dr");
            cmp_val(o_rx_buffer, rx_d[i], "rx data");
            cmp_val(8'(o_status[3:0]), 8'(rx_f[i]), "rx flags");
            if (rx_f[i] != 4'h0)
                cmp_val(8'(o_interrupt_request), 8'h01, "rx irq");
            if (rx_rd[i])
            begin
                strobe(RR, 8'h00);
                strobe(RS, 8'h00);
                cmp_val({o_rx_data_ready, o_status[7], o_interrupt_request}, 3'b000, "read");
            end
            tick(4);
        end
        $display("test receive done");
        i_parity_en = 1'b0;
        i_interrupt_enable_bit     = 1'b0;
        remote.rx_q.delete();
        i_tx_valid = 1'b1;
        i_tx_data  = 8'hA5;
        tick(1);
        i_tx_valid = 1'b0;
        tbe_to_start();
        frames(1, 1'b0);
        cmp_val(remote.rx_q[0], 8'hA5, "single frame");
        $display("test single transmit done");
        i_interrupt_enable_bit = 1'b1;
        remote.set_modem(1'b1, 1'b1);
        tick(2);
        strobe(RS, 8'h00);
        remote.rx_q.delete();
        remote.stop_q.delete();
        n = 0;
        i_tx_valid = 1'b1;
        while (o_tx_ready === 1'b1 && n < 40)
        begin
            i_tx_data = 8'(n + 16);
            tick(1);
            n++;
        end
        i_tx_valid = 1'b0;
        cmp_cnt(n, UCX_FIFO_DEPTH + 1, "words accepted");
        tick(40);
        cmp_val({o_tx_buffer_empty, o_status[6], o_serial_out}, 3'b001, "held by cts");
        remote.set_modem(1'b0, 1'b1);
        tbe_to_start();
        tbe_to_start();
        frames(n, 1'b1);
        for (int i = 0; i < n; i++)
        begin
            cmp_val(remote.rx_q[i], 8'(i + 16), "burst data");
            if (i > 0)
                cmp_cnt(remote.stop_q[i], UCX_BIT_TICKS, "chained stop bit");
        end
        $display("test burst transmit done");
        give_verdict();
    end
endmodule : ucx_uart_tb_top
